//--- core/mftc_core.sv
// Purpose: Multifunction timer core: prescaler, counter, compares, triggers, outputs
// Assumes: Pins synchronous to clk_sys_i; control bits are plain ports
// Notes:   Interrupt requests are single-cycle pulses for an external interrupt controller
`timescale 1ns/1ps

// Overview of operation
// - 16-bit counter behind 8-bit prescaler, clock/3
// - Two compare and two load/capture registers
// - Inputs detect rise, fall or both edges
// - Each output driven by cmp0, cmp1, eoc
// - Per source action: nop, set, reset, toggle
// - On-chip event from eoc or compare 0
// - Five masked sources into three prioritized requests
// - Two DMA requests override matching interrupts
// - Control and mode bits select operation
// - Triggers from soft bits or input edges
// - Trigger captures or loads per mode
// - Input A or soft 0 targets register 0
// - Input B or soft 1 targets register 1
// - Load-monitor mode lets input B trigger reg0
// - One-shot end of count halts, no reload
// - One-shot restart by A, B or soft 0
// - One-shot select picks one-shot or continuous
// - Continuous mode reloads at end of count
// - Biload alternates, first reload from reg0
// - Triggered ignores early triggers; retriggered reloads
// - Retrigger enable selects triggered or retriggered
module mftc_core
  import mftc_pkg::*;
(
  input  wire logic                         clk_sys_i,
  input  wire logic                         rstn_i,
  input  wire mftc_pkg::mftc_ctrl_t         ctrl_i,
  input  wire mftc_pkg::mftc_edge_t         input_a_edge_select_i,
  input  wire mftc_pkg::mftc_edge_t         input_b_edge_select_i,
  input  wire mftc_pkg::mftc_out_cfg_t      out0_cfg_i,
  input  wire mftc_pkg::mftc_out_cfg_t      out1_cfg_i,
  input  wire mftc_pkg::mftc_irq_src_t      irq_mask_i,
  input  wire logic                         dma0_cap_en_i,
  input  wire logic                         dma0_cmp_en_i,
  input  wire logic                         soft_trigger_0_i,
  input  wire logic                         soft_trigger_1_i,
  input  wire logic                         reg0_wr_i,
  input  wire logic                         reg1_wr_i,
  input  wire logic                         cmp0_wr_i,
  input  wire logic                         cmp1_wr_i,
  input  wire logic [mftc_pkg::CNT_W-1:0]   wdata_i,
  input  wire logic                         ext_clk_i,
  input  wire logic                         event_input_a_i,
  input  wire logic                         event_input_b_i,
  output logic      [mftc_pkg::CNT_W-1:0]   count_o,
  output logic      [mftc_pkg::CNT_W-1:0]   load_capture_reg_0_o,
  output logic      [mftc_pkg::CNT_W-1:0]   load_capture_reg_1_o,
  output logic                              running_o,
  output logic                              out0_o,
  output logic                              out1_o,
  output logic                              on_chip_event_o,
  output logic                              irq_eoc_o,
  output logic                              irq_cap_o,
  output logic                              irq_cmp_o,
  output logic                              dma_cap0_req_o,
  output logic                              dma_cmp0_req_o
);
  import mftc_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] reg0_q;
  logic [CNT_W-1:0] reg1_q;
  logic [CNT_W-1:0] cmp0_q;
  logic [CNT_W-1:0] cmp1_q;
  logic [1:0]       div3_q;
  logic [PSC_W-1:0] psc_q;
  logic             ina_q;
  logic             inb_q;
  logic             extc_q;
  logic             run_q;
  logic             bisel_q;
  logic             bm_q;
  logic             out0_q;
  logic             out1_q;
  logic             evt_q;
  logic             cap0_ev_q;
  logic             cap1_ev_q;
  logic             cmp0_ev_q;
  logic             cmp1_ev_q;
  logic             eoc_ev_q;

  function automatic logic edge_hit(input mftc_edge_t sel, input logic prev, input logic cur);
    edge_hit = ((sel == EDGE_RISE) || (sel == EDGE_BOTH)) && !prev && cur
            || ((sel == EDGE_FALL) || (sel == EDGE_BOTH)) && prev && !cur;
  endfunction

  function automatic logic apply_act(input mftc_act_t act, input logic ev, input logic cur);
    apply_act = cur;
    if (ev)
    begin
      unique case (act)
        ACT_NOP:    apply_act = cur;
        ACT_SET:    apply_act = 1'b1;
        ACT_RESET:  apply_act = 1'b0;
        ACT_TOGGLE: apply_act = ~cur;
      endcase
    end
  endfunction

  // Edge detection on pins that are already synchronous
  logic ev_a;
  logic ev_b;
  logic ext_tick;
  logic core_tick;
  logic psc_tick;
  logic psc_done;
  logic step;
  logic eoc;
  logic trig0;
  logic trig1;
  logic restart;
  logic ignore_trig;
  logic load0;
  logic monitor1;

  assign ev_a     = edge_hit(input_a_edge_select_i, ina_q, event_input_a_i);
  assign ev_b     = edge_hit(input_b_edge_select_i, inb_q, event_input_b_i);
  assign ext_tick = ext_clk_i && !extc_q;
  assign core_tick = (div3_q == CLK_DIV_MAX);
  assign psc_tick = ctrl_i.ext_clock ? ext_tick : core_tick;
  // Limit test uses >= so a prescale lowered mid-count cannot stall for a full wrap
  assign psc_done = psc_tick && (psc_q >= ctrl_i.prescale);
  assign step     = psc_done && run_q && ctrl_i.run;
  assign eoc      = step && (ctrl_i.count_down ? (cnt_q == CNT_ZERO)
                                               : (cnt_q == CNT_ONES));
  assign monitor1 = !ctrl_i.capture1 && !ctrl_i.bivalue_select;
  // Bicapture routes input A by bisel_q in the capture path; bisel_q does not toggle while capture0 is set
  assign trig0    = ev_a || soft_trigger_0_i
                 || (ev_b && ctrl_i.input_b_to_reg0 && !ctrl_i.capture0 && monitor1);
  assign trig1    = (ev_b || soft_trigger_1_i) && !ctrl_i.input_b_to_reg0;
  // Restart after halt: only A, B or soft 0; soft 1 never restarts
  assign restart  = ctrl_i.one_shot_select && !run_q
                 && (ev_a || ev_b || soft_trigger_0_i);
  // Triggered mode masks triggers while running; in continuous mode all are masked
  assign ignore_trig = !ctrl_i.retrigger_en
                    && (run_q || !ctrl_i.one_shot_select);
  assign load0    = !ctrl_i.capture0 && (restart || (trig0 && !ignore_trig));

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      ina_q  <= 1'b0;
      inb_q  <= 1'b0;
      extc_q <= 1'b0;
    end
    else
    begin
      ina_q  <= event_input_a_i;
      inb_q  <= event_input_b_i;
      extc_q <= ext_clk_i;
    end
  end

  // Divide-by-three and programmable prescaler
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      div3_q <= 2'h0;
      psc_q  <= PSC_RST;
    end
    else
    begin
      div3_q <= core_tick ? 2'h0 : div3_q + 2'h1;
      if (psc_done)
        psc_q <= PSC_RST;
      else if (psc_tick)
        psc_q <= psc_q + 8'h01;
    end
  end

  // Counter with one-shot halt, continuous reload, biload alternation
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      cnt_q   <= CNT_RST;
      run_q   <= 1'b1;
      bisel_q <= 1'b0;
      bm_q    <= 1'b0;
    end
    else
    begin
      bm_q <= ctrl_i.bivalue_select;
      if (!ctrl_i.bivalue_select || (ctrl_i.bivalue_select && !bm_q))
        bisel_q <= 1'b0;
      if (load0)
      begin
        cnt_q   <= reg0_q;
        run_q   <= 1'b1;
        bisel_q <= 1'b0;
      end
      else if (eoc && ctrl_i.one_shot_select)
        run_q <= 1'b0;
      else if (eoc && ctrl_i.capture0)
        cnt_q <= ctrl_i.count_down ? CNT_ONES : CNT_ZERO;  // Free running wrap
      else if (eoc)
      begin
        cnt_q <= (ctrl_i.bivalue_select && bisel_q) ? reg1_q : reg0_q;
        if (ctrl_i.bivalue_select && bm_q)
          bisel_q <= ~bisel_q;
      end
      else if (step)
        cnt_q <= ctrl_i.count_down ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
      if (!ctrl_i.one_shot_select)
        run_q <= 1'b1;
    end
  end

  // Load/capture registers; bicapture target follows bisel_q, which never toggles while capture0 is set
  logic cap0_now;
  logic cap1_now;
  logic bicap;
  assign bicap    = ctrl_i.bivalue_select && ctrl_i.capture0;
  assign cap0_now = ctrl_i.capture0 && trig0 && !(bicap && bisel_q);
  assign cap1_now = (ctrl_i.capture1 && trig1) || (bicap && trig0 && bisel_q);

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      reg0_q <= CNT_RST;
      reg1_q <= CNT_RST;
      cmp0_q <= CNT_RST;
      cmp1_q <= CNT_RST;
    end
    else
    begin
      if (cap0_now)
        reg0_q <= cnt_q;
      else if (reg0_wr_i)
        reg0_q <= wdata_i;
      if (cap1_now || (monitor1 && !bicap))
        reg1_q <= cnt_q;
      else if (reg1_wr_i)
        reg1_q <= wdata_i;
      if (cmp0_wr_i)
        cmp0_q <= wdata_i;
      if (cmp1_wr_i)
        cmp1_q <= wdata_i;
    end
  end

  // Single-cycle event pulses, one per cause
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      cap0_ev_q <= 1'b0;
      cap1_ev_q <= 1'b0;
      cmp0_ev_q <= 1'b0;
      cmp1_ev_q <= 1'b0;
      eoc_ev_q  <= 1'b0;
    end
    else
    begin
      cap0_ev_q <= cap0_now;
      cap1_ev_q <= cap1_now;
      cmp0_ev_q <= step && (cnt_q == cmp0_q);
      cmp1_ev_q <= step && (cnt_q == cmp1_q);
      eoc_ev_q  <= eoc;
    end
  end

  // Output pins and on-chip event
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      out0_q <= 1'b0;
      out1_q <= 1'b0;
      evt_q  <= 1'b0;
    end
    else
    begin
      // Sources applied in order cmp0, cmp1, eoc; the later source wins on a tie
      out0_q <= apply_act(out0_cfg_i.eoc, eoc_ev_q,
                apply_act(out0_cfg_i.cmp1, cmp1_ev_q,
                apply_act(out0_cfg_i.cmp0, cmp0_ev_q, out0_q)));
      out1_q <= apply_act(out1_cfg_i.eoc, eoc_ev_q,
                apply_act(out1_cfg_i.cmp1, cmp1_ev_q,
                apply_act(out1_cfg_i.cmp0, cmp0_ev_q, out1_q)));
      evt_q  <= ctrl_i.event_src_cmp0 ? cmp0_ev_q : eoc_ev_q;
    end
  end

  // Interrupt grouping; DMA steals the source it serves
  logic cap0_irq;
  logic cmp0_irq;
  assign cap0_irq = cap0_ev_q && irq_mask_i.cap0 && !dma0_cap_en_i;
  assign cmp0_irq = cmp0_ev_q && irq_mask_i.cmp0 && !dma0_cmp_en_i;
  assign irq_eoc_o = eoc_ev_q && irq_mask_i.eoc;
  assign irq_cap_o = !irq_eoc_o && (cap0_irq || (cap1_ev_q && irq_mask_i.cap1));
  assign irq_cmp_o = !irq_eoc_o && !irq_cap_o
                  && (cmp0_irq || (cmp1_ev_q && irq_mask_i.cmp1));
  assign dma_cap0_req_o = cap0_ev_q && dma0_cap_en_i;
  assign dma_cmp0_req_o = cmp0_ev_q && dma0_cmp_en_i;

  assign count_o              = cnt_q;
  assign load_capture_reg_0_o = reg0_q;
  assign load_capture_reg_1_o = reg1_q;
  assign running_o            = run_q;
  assign out0_o               = out0_q;
  assign out1_o               = out1_q;
  assign on_chip_event_o      = evt_q;

endmodule

//--- shared/mftc_pkg.sv
// Purpose: Shared constants and carrier types for the multifunction timer core
// Assumes: Single clock domain, synchronous active-low reset
// Notes:   Action, edge and source encodings are local choices
package mftc_pkg;

  localparam int unsigned CNT_W       = 16;
  localparam int unsigned PSC_W       = 8;
  localparam int unsigned CLK_DIV     = 3;
  localparam logic [1:0]  CLK_DIV_MAX = 2'h2;
  localparam logic [15:0] CNT_RST     = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO    = 16'h0000;
  localparam logic [15:0] CNT_ONES    = 16'hFFFF;
  localparam logic [7:0]  PSC_RST     = 8'h00;

  typedef enum logic [1:0] { ACT_NOP, ACT_SET, ACT_RESET, ACT_TOGGLE } mftc_act_t;
  typedef enum logic [1:0] { EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH } mftc_edge_t;

  // Actions per output for each source: compare 0, compare 1, end of count
  typedef struct packed {
    mftc_act_t cmp0;
    mftc_act_t cmp1;
    mftc_act_t eoc;
  } mftc_out_cfg_t;

  // Timer control and mode bits
  typedef struct packed {
    logic       run;          // Counter enable
    logic       count_down;   // Counting direction
    logic       ext_clock;    // Prescaler fed by external clock input
    logic       one_shot_select;
    logic       retrigger_en;
    logic       bivalue_select;
    logic       capture0;     // Register 0 captures instead of loading
    logic       capture1;     // Register 1 captures instead of monitoring
    logic       event_src_cmp0; // On-chip event from compare 0 instead of eoc
    logic       input_b_to_reg0;
    logic [7:0] prescale;
  } mftc_ctrl_t;

  typedef struct packed {
    logic eoc;
    logic cap0;
    logic cap1;
    logic cmp0;
    logic cmp1;
  } mftc_irq_src_t;

endpackage

//--- sim/mftc_pin_model.sv
// Purpose: Drives the timer's event pins and external clock pin
// Assumes: Pin levels change on the falling clock edge
// Notes:   External clock stands low except while a burst of edges is sent
`timescale 1ns/1ps
module mftc_pin_model (
  input  wire logic clk_sys_i,
  output logic      event_input_a_o,
  output logic      event_input_b_o,
  output logic      ext_clk_o
);
  initial
  begin
    event_input_a_o = 1'b0;
    event_input_b_o = 1'b0;
    ext_clk_o       = 1'b0;
  end

  // Level held four cycles so the core sees one clean edge
  task automatic drive_pin(input logic sel_b, input logic level);
    @(negedge clk_sys_i);
    if (sel_b)
      event_input_b_o = level;
    else
      event_input_a_o = level;
    repeat (4) @(negedge clk_sys_i);
  endtask

  // Two cycles per level keep every rising edge apart for the core
  task automatic ext_pulse(input int k);
    repeat (k)
    begin
      @(negedge clk_sys_i);
      ext_clk_o = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      ext_clk_o = 1'b0;
      @(negedge clk_sys_i);
    end
  endtask
endmodule

//--- sim/mftc_core_properties.sv
// Purpose: Port-level properties of the timer core
// Assumes: Single clock, synchronous active-low reset
// Notes:   Step spacing checked only where triggers are ignored
`timescale 1ns/1ps
module mftc_core_properties
  import mftc_pkg::*;
(
  input wire logic                       clk_sys_i,
  input wire logic                       rstn_i,
  input wire mftc_pkg::mftc_ctrl_t       ctrl_i,
  input wire mftc_pkg::mftc_out_cfg_t    out0_cfg_i,
  input wire logic                       dma0_cmp_en_i,
  input wire logic [mftc_pkg::CNT_W-1:0] count_o,
  input wire logic                       running_o,
  input wire logic                       out0_o,
  input wire logic                       on_chip_event_o,
  input wire logic                       irq_eoc_o,
  input wire logic                       irq_cap_o,
  input wire logic                       irq_cmp_o,
  input wire logic                       dma_cmp0_req_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  a_eoc_pulse: assert property (irq_eoc_o |=> !irq_eoc_o)
    else $error("end of count request longer than one cycle");
  a_cmp_pulse: assert property (irq_cmp_o |=> !irq_cmp_o)
    else $error("compare request longer than one cycle");
  a_irq_priority: assert property (irq_eoc_o |-> !irq_cap_o && !irq_cmp_o)
    else $error("lower request beside end of count");
  a_dma_route: assert property (dma_cmp0_req_o |-> dma0_cmp_en_i && !irq_cmp_o)
    else $error("compare request not replaced by dma");
  a_event_pulse: assert property (on_chip_event_o |=> !on_chip_event_o)
    else $error("on-chip event longer than one cycle");
  a_halt_hold: assert property (!running_o ##1 !running_o |-> $stable(count_o))
    else $error("halted counter moved");
  a_oneshot_halt: assert property (irq_eoc_o && ctrl_i.one_shot_select
    |-> ##[0:2] !running_o)
    else $error("one-shot did not halt");
  // Reloads in continuous triggered mode only come at a step, so spacing holds
  a_step_spacing: assert property ((ctrl_i.run && !ctrl_i.ext_clock
    && !ctrl_i.one_shot_select && !ctrl_i.retrigger_en && $changed(count_o))
    |=> $stable(count_o) [*2])
    else $error("counter stepped faster than the prescaled clock");
  a_out_nop: assert property ((out0_cfg_i == '0 && $past(out0_cfg_i) == '0
    && $past(out0_cfg_i, 2) == '0) |-> $stable(out0_o))
    else $error("output moved with all actions idle");
endmodule

bind mftc_core mftc_core_properties u_props (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ctrl_i(ctrl_i), .out0_cfg_i(out0_cfg_i),
  .dma0_cmp_en_i(dma0_cmp_en_i), .count_o(count_o), .running_o(running_o),
  .out0_o(out0_o), .on_chip_event_o(on_chip_event_o), .irq_eoc_o(irq_eoc_o),
  .irq_cap_o(irq_cap_o), .irq_cmp_o(irq_cmp_o), .dma_cmp0_req_o(dma_cmp0_req_o)
);

//--- sim/testbench.sv
// Purpose: Self-checking bench for the multifunction timer core
// Assumes: Inputs change on the falling clock edge
// Notes:   Prescaler at divide by one, two in the retrigger test, keeps each count cycle short
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module testbench;
  import mftc_pkg::*;
  logic          clk_sys_i = 1'b0;
  logic          rstn_i = 1'b0;
  mftc_ctrl_t    ctrl = '0;
  mftc_edge_t    edge_a = EDGE_NONE;
  mftc_edge_t    edge_b = EDGE_NONE;
  mftc_out_cfg_t out0_cfg = '0;
  mftc_out_cfg_t out1_cfg = '0;
  logic          dma_en = 1'b0;
  mftc_irq_src_t irq_mask = 5'h1F;
  logic [1:0]    st = 2'h0;
  logic [3:0]    wr_s = 4'h0;
  logic [15:0]   wdata = 16'h0000;
  logic          ext_clk, pin_a, pin_b, running, out0, out1, oce;
  logic          irq_eoc, irq_cap, irq_cmp, dma_cap, dma_cmp;
  logic [15:0]   count, reg0, reg1, snap;
  int            n_mismatch = 0;
  int            cmp_count = 0;
  int            cycles = 0;
  int            n;

  mftc_pin_model pins (.clk_sys_i(clk_sys_i), .event_input_a_o(pin_a),
    .event_input_b_o(pin_b), .ext_clk_o(ext_clk));
  mftc_core uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ctrl_i(ctrl),
    .input_a_edge_select_i(edge_a), .input_b_edge_select_i(edge_b),
    .out0_cfg_i(out0_cfg), .out1_cfg_i(out1_cfg), .irq_mask_i(irq_mask),
    .dma0_cap_en_i(dma_en), .dma0_cmp_en_i(dma_en), .soft_trigger_0_i(st[0]),
    .soft_trigger_1_i(st[1]), .reg0_wr_i(wr_s[0]), .reg1_wr_i(wr_s[1]),
    .cmp0_wr_i(wr_s[2]), .cmp1_wr_i(wr_s[3]), .wdata_i(wdata), .ext_clk_i(ext_clk),
    .event_input_a_i(pin_a), .event_input_b_i(pin_b), .count_o(count),
    .load_capture_reg_0_o(reg0), .load_capture_reg_1_o(reg1), .running_o(running),
    .out0_o(out0), .out1_o(out1), .on_chip_event_o(oce), .irq_eoc_o(irq_eoc),
    .irq_cap_o(irq_cap), .irq_cmp_o(irq_cmp), .dma_cap0_req_o(dma_cap),
    .dma_cmp0_req_o(dma_cmp));

  always #20 clk_sys_i = ~clk_sys_i;

  // Whole run needs about 600 cycles; the ceiling leaves wide margin
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask

  task automatic pulse(input int sel, input logic [15:0] val);
    @(negedge clk_sys_i);
    wdata = val;
    if (sel < 4)
      wr_s[sel] = 1'b1;
    else
      st[sel-4] = 1'b1;
    @(negedge clk_sys_i);
    wr_s = 4'h0;
    st = 2'h0;
  endtask

  task automatic wait_ev(input int sel);
    for (n = 0; n < 300; n++)
    begin
      if ((sel == 0 && irq_eoc === 1'b1) || (sel == 1 && irq_cmp === 1'b1)
          || (sel == 2 && dma_cmp === 1'b1))
        return;
      @(negedge clk_sys_i);
    end
    `CHK("event wait", 1'b1, 1'b0)
  endtask

  task automatic t_reload;
    pulse(0, 16'hFFFD);
    pulse(2, 16'hFFFE);
    ctrl.run = 1'b1;
    wait_ev(0);
    `CHK("reload value", 16'hFFFD, count)
    tick(1);
    wait_ev(0);
    `CHK("cycle spacing", 8, n)
  endtask

  task automatic t_outputs;
    mftc_act_t acts [5] = '{ACT_SET, ACT_TOGGLE, ACT_TOGGLE, ACT_RESET, ACT_NOP};
    logic [4:0] exp_lv = 5'h05;
    ctrl.event_src_cmp0 = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      out0_cfg.cmp0 = acts[i];
      out1_cfg.eoc = acts[i];
      wait_ev(1);
      tick(1);
      `CHK("out0", exp_lv[i], out0)
      `CHK("event on compare", 1'b1, oce)
      wait_ev(0);
      tick(1);
      `CHK("out1", exp_lv[i], out1)
      `CHK("no event on eoc", 1'b0, oce)
    end
    dma_en = 1'b1;
    wait_ev(2);
    `CHK("irq beside dma", 1'b0, irq_cmp)
    dma_en = 1'b0;
  endtask

  task automatic t_oneshot;
    ctrl.one_shot_select = 1'b1;
    wait_ev(0);
    tick(1);
    `CHK("halted", 1'b0, running)
    snap = count;
    pulse(5, 16'h0000);
    tick(4);
    `CHK("soft 1 restart", 1'b0, running)
    `CHK("halt value", snap, count)
    pulse(4, 16'h0000);
    tick(4);
    `CHK("soft 0 restart", 1'b1, running)
    wait_ev(0);
    edge_a = EDGE_RISE;
    pins.drive_pin(1'b0, 1'b1);
    `CHK("pin restart", 1'b1, running)
  endtask

  task automatic t_capture;
    logic hit;
    ctrl = '0;
    ctrl.capture0 = 1'b1;
    ctrl.capture1 = 1'b1;
    for (int m = 0; m < 8; m++)
    begin
      edge_a = EDGE_NONE;
      pins.drive_pin(1'b0, !m[0]);
      pulse(0, 16'h1234);
      edge_a = mftc_edge_t'(m[2:1]);
      pins.drive_pin(1'b0, m[0]);
      hit = (m[2:1] == 2'h3) || (m[2:1] == 2'h1 && m[0]) || (m[2:1] == 2'h2 && !m[0]);
      `CHK("edge capture", hit ? count : 16'h1234, reg0)
    end
    edge_b = EDGE_FALL;
    pins.drive_pin(1'b1, 1'b1);
    pulse(1, 16'h5678);
    pins.drive_pin(1'b1, 1'b0);
    `CHK("pin b capture", count, reg1)
    pulse(1, 16'h5678);
    pulse(5, 16'h0000);
    tick(3);
    `CHK("soft 1 capture", count, reg1)
    pulse(0, 16'h1234);
    pulse(4, 16'h0000);
    `CHK("capture irq", 1'b1, irq_cap)
    tick(3);
    `CHK("soft 0 capture", count, reg0)
    dma_en = 1'b1;
    pulse(4, 16'h0000);
    `CHK("capture dma", 2'h2, {dma_cap, irq_cap})
    dma_en = 1'b0;
    irq_mask.cap0 = 1'b0;
    pulse(4, 16'h0000);
    `CHK("masked capture", 1'b0, irq_cap)
    irq_mask = 5'h1F;
  endtask

  task automatic t_retrigger;
    ctrl = '0;
    ctrl.count_down = 1'b1;
    ctrl.prescale = 8'h01;
    ctrl.one_shot_select = 1'b1;
    ctrl.retrigger_en = 1'b1;
    ctrl.input_b_to_reg0 = 1'b1;
    ctrl.run = 1'b1;
    pulse(0, 16'h0005);
    pulse(4, 16'h0000);
    `CHK("retrigger load", 16'h0005, count)
    pulse(0, 16'h0021);
    pins.drive_pin(1'b1, 1'b1);
    pins.drive_pin(1'b1, 1'b0);
    `CHK("input b loads reg0", 1'b1, count >= 16'h0020)
    wait_ev(0);
    tick(1);
    `CHK("down halt", 17'h0_0000, {running, count})
    ctrl.retrigger_en = 1'b0;
    pulse(0, 16'h0005);
    pulse(4, 16'h0000);
    `CHK("halted restart", 17'h1_0005, {running, count})
    pulse(0, 16'h0040);
    pulse(4, 16'h0000);
    `CHK("running trigger ignored", 1'b1, count <= 16'h0005)
    wait_ev(0);
    tick(1);
  endtask

  task automatic t_biload;
    ctrl.one_shot_select = 1'b0;
    ctrl.run = 1'b0;
    ctrl.prescale = 8'h00;
    ctrl.input_b_to_reg0 = 1'b0;
    ctrl.bivalue_select = 1'b1;
    pulse(0, 16'h0002);
    pulse(1, 16'h0004);
    ctrl.run = 1'b1;
    wait_ev(0);
    `CHK("biload first", 16'h0002, count)
    tick(1);
    `CHK("event on eoc", 1'b1, oce)
    wait_ev(0);
    `CHK("biload second", 16'h0004, count)
    tick(1);
    wait_ev(0);
    `CHK("biload third", 16'h0002, count)
  endtask

  task automatic t_ext_clock;
    ctrl = '0;
    ctrl.ext_clock = 1'b1;
    ctrl.capture0 = 1'b1;
    ctrl.run = 1'b1;
    snap = count;
    pins.ext_pulse(3);
    `CHK("external clock steps", snap + 16'h0003, count)
  endtask

  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    tick(8);
    rstn_i = 1'b1;
    tick(1);
    `CHK("reset count", 16'hFFFF, count)
    `CHK("reset reg0", 16'hFFFF, reg0)
    `CHK("reset reg1", 16'hFFFF, reg1)
    `CHK("reset outputs", 3'h1, {out0, out1, running})
    t_reload();
    t_outputs();
    t_oneshot();
    t_capture();
    t_retrigger();
    t_biload();
    t_ext_clock();
    finish_test();
  end
endmodule
